// *** irq_vector_ctrl.sv ***
// Vectored interrupt controller with return stack and power-down wake-up.
// Assumes the sequencer pulses call and return strobes for one cycle each,
// presents the current program counter on PC_I, and drives the second
// phase pulse once per machine cycle.
// Behaviour
// - Global enable low blocks every acknowledgment
// - Bits 1-3 enable pin, tick, conversion
// - Bits 4-6 hold flags; bit 7 reads zero
// - Pin falling edge sets pin flag
// - Pin request vectors to 04H, clears flag, enable
// - Tick overflow sets flag, vectors to 08H
// - Conversion done sets flag, vectors to 0CH
// - Flags still set while globally disabled
// - Software re-enable inside handler allows nesting
// - Full stack holds acknowledgment, flag stays pending
// - Acknowledgment pushes only the program counter
// - Service return sets enable; plain return not
// - Requests are evaluated on second phase pulse
// - Priority: pin, then tick, then conversion
// - Flags stay set until serviced or cleared
// - Request from a source whose flag was clear at power-down entry wakes
// - Return stack holds six entries
// - Flag already set at power-down disables wake
`timescale 1ns/1ps
module irq_vector_ctrl
    import irq_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                                CLK_I,
    input  wire logic                                RSTN_I,
    // AXI4-Lite register port
    input  wire logic [irq_ctrl_pkg::AXI_ADDR_W-1:0] AWADDR_I,
    input  wire logic                                AWVALID_I,
    output logic                                     AWREADY_O,
    input  wire logic [irq_ctrl_pkg::AXI_DATA_W-1:0] WDATA_I,
    input  wire logic [3:0]                          WSTRB_I,
    input  wire logic                                WVALID_I,
    output logic                                     WREADY_O,
    output logic [1:0]                               BRESP_O,
    output logic                                     BVALID_O,
    input  wire logic                                BREADY_I,
    input  wire logic [irq_ctrl_pkg::AXI_ADDR_W-1:0] ARADDR_I,
    input  wire logic                                ARVALID_I,
    output logic                                     ARREADY_O,
    output logic [irq_ctrl_pkg::AXI_DATA_W-1:0]      RDATA_O,
    output logic [1:0]                               RRESP_O,
    output logic                                     RVALID_O,
    input  wire logic                                RREADY_I,
    // Request sources
    input  wire logic                                PIN_IRQ_N_I,
    input  wire logic                                TICK_OVF_I,
    input  wire logic                                CONV_DONE_I,
    // Sequencer
    input  wire logic                                PHASE2_I,
    input  wire logic [irq_ctrl_pkg::PC_W-1:0]       PC_I,
    input  wire logic                                SUB_CALL_I,
    input  wire logic                                SUB_RET_I,
    input  wire logic                                SVC_RET_I,
    input  wire logic                                POWER_DOWN_I,
    output logic                                     VEC_CALL_O,
    output logic [irq_ctrl_pkg::PC_W-1:0]            VEC_ADDR_O,
    output logic [irq_ctrl_pkg::PC_W-1:0]            RET_PC_O,
    output logic                                     RET_VALID_O,
    output logic                                     STACK_FULL_O,
    output logic                                     WAKE_O
);
    import irq_ctrl_pkg::*;

    reg_access_if regs ();

    logic                   gie_q, gie_d;
    logic [NUM_SRC-1:0]     en_q, en_d, flag_q, flag_d, armed_q, armed_d;
    logic [NUM_SRC-1:0]     set_ev, pend;
    logic                   pin_prev_q, pd_q, wake_d;
    logic [STACK_PTR_W-1:0] cnt_q, cnt_d, top_q, top_d, top_next, top_prev;
    logic                   full, pop, push, ack, ctrl_wr, ret_valid_d;
    logic [PC_W-1:0]        vaddr_d;
    logic [NUM_SRC-1:0]     ack_mask;

    axil_reg_slave u_slave (
        .clk_i     (CLK_I),
        .rst_ni    (RSTN_I),
        .awaddr_i  (AWADDR_I),
        .awvalid_i (AWVALID_I),
        .awready_o (AWREADY_O),
        .wdata_i   (WDATA_I),
        .wstrb_i   (WSTRB_I),
        .wvalid_i  (WVALID_I),
        .wready_o  (WREADY_O),
        .bresp_o   (BRESP_O),
        .bvalid_o  (BVALID_O),
        .bready_i  (BREADY_I),
        .araddr_i  (ARADDR_I),
        .arvalid_i (ARVALID_I),
        .arready_o (ARREADY_O),
        .rdata_o   (RDATA_O),
        .rresp_o   (RRESP_O),
        .rvalid_o  (RVALID_O),
        .rready_i  (RREADY_I),
        .regs      (regs.bus)
    );

    // Register decode and read mux.
    always_comb begin
        regs.wr_ok   = 1'b0;
        regs.rd_ok   = 1'b0;
        regs.rd_data = '0;
        if (regs.wr_idx == INT_CTRL_IDX) begin
            regs.wr_ok = 1'b1;
        end else if (regs.wr_idx == STACK_STAT_IDX) begin
            regs.wr_ok = 1'b1;
        end
        if (regs.rd_idx == INT_CTRL_IDX) begin
            regs.rd_ok   = 1'b1;
            regs.rd_data = {1'b0, flag_q, en_q, gie_q};
        end else if (regs.rd_idx == STACK_STAT_IDX) begin
            regs.rd_ok   = 1'b1;
            regs.rd_data = {4'h0, full, cnt_q};
        end
    end

    assign ctrl_wr = regs.wr_stb & regs.wr_lane0 & (regs.wr_idx == INT_CTRL_IDX);

    // Hardware request events.
    assign set_ev[SRC_PIN]  = pin_prev_q & ~PIN_IRQ_N_I;
    assign set_ev[SRC_TICK] = TICK_OVF_I;
    assign set_ev[SRC_CONV] = CONV_DONE_I;

    // Stack pointer arithmetic; the oldest entry is overwritten when a plain
    // call runs on a full stack, so only the latest six addresses survive.
    assign full     = (cnt_q == STACK_FULL_CNT);
    assign top_next = (top_q == STACK_LAST) ? STACK_ZERO : top_q + STACK_ONE;
    assign top_prev = (top_q == STACK_ZERO) ? STACK_LAST : top_q - STACK_ONE;
    assign pop      = (SUB_RET_I | SVC_RET_I) & (cnt_q != STACK_ZERO);

    // Acknowledge only on the phase pulse and never while the sequencer
    // itself moves the stack, which keeps one push or pop per cycle.
    assign pend = flag_q & en_q;
    assign ack  = PHASE2_I & gie_q & (|pend) & ~full
                  & ~SUB_CALL_I & ~pop;
    assign push = ack | SUB_CALL_I;

    // Fixed priority select of the serviced source.
    always_comb begin
        ack_mask = '0;
        vaddr_d  = VEC_ADDR_O;
        if (pend[SRC_PIN]) begin
            ack_mask[SRC_PIN] = 1'b1;
            vaddr_d           = VEC_PIN;
        end else if (pend[SRC_TICK]) begin
            ack_mask[SRC_TICK] = 1'b1;
            vaddr_d            = VEC_TICK;
        end else if (pend[SRC_CONV]) begin
            ack_mask[SRC_CONV] = 1'b1;
            vaddr_d            = VEC_CONV;
        end
        if (!ack) begin
            vaddr_d = VEC_ADDR_O;
        end
    end

    // Control register next state.
    always_comb begin
        gie_d  = gie_q;
        en_d   = en_q;
        flag_d = flag_q;
        if (ctrl_wr) begin
            gie_d  = regs.wr_data[GIE_BIT];
            en_d   = regs.wr_data[EN_LSB +: NUM_SRC];
            flag_d = regs.wr_data[FLAG_LSB +: NUM_SRC];
        end
        if (SVC_RET_I) begin
            gie_d = 1'b1;
        end
        if (ack) begin
            flag_d = flag_d & ~ack_mask;
            gie_d  = 1'b0;
        end
        flag_d = flag_d | set_ev;
    end

    // Stack next state.
    always_comb begin
        cnt_d       = cnt_q;
        top_d       = top_q;
        ret_valid_d = pop;
        if (push) begin
            top_d = top_next;
            if (!full) begin
                cnt_d = cnt_q + STACK_ONE;
            end
        end else if (pop) begin
            top_d = top_prev;
            cnt_d = cnt_q - STACK_ONE;
        end
    end

    // Wake-up arms on entry to power-down for sources whose flag is clear.
    always_comb begin
        armed_d = armed_q;
        if (POWER_DOWN_I && !pd_q) begin
            armed_d = ~flag_q;
        end
        wake_d = POWER_DOWN_I & pd_q & (|(set_ev & armed_q));
    end

    return_stack_mem u_stack (
        .clk_i     (CLK_I),
        .rst_ni    (RSTN_I),
        .wr_en_i   (push),
        .wr_idx_i  (top_q),
        .wr_data_i (PC_I),
        .rd_en_i   (pop),
        .rd_idx_i  (top_prev),
        .rd_data_o (RET_PC_O)
    );

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            gie_q        <= INT_CTRL_RESET[GIE_BIT];
            en_q         <= INT_CTRL_RESET[EN_LSB +: NUM_SRC];
            flag_q       <= INT_CTRL_RESET[FLAG_LSB +: NUM_SRC];
            armed_q      <= '0;
            pin_prev_q   <= 1'b1;
            pd_q         <= 1'b0;
            cnt_q        <= STACK_ZERO;
            top_q        <= STACK_ZERO;
            VEC_CALL_O   <= 1'b0;
            VEC_ADDR_O   <= PC_RESET;
            RET_VALID_O  <= 1'b0;
            STACK_FULL_O <= 1'b0;
            WAKE_O       <= 1'b0;
        end else begin
            gie_q        <= gie_d;
            en_q         <= en_d;
            flag_q       <= flag_d;
            armed_q      <= armed_d;
            pin_prev_q   <= PIN_IRQ_N_I;
            pd_q         <= POWER_DOWN_I;
            cnt_q        <= cnt_d;
            top_q        <= top_d;
            VEC_CALL_O   <= ack;
            VEC_ADDR_O   <= vaddr_d;
            RET_VALID_O  <= ret_valid_d;
            STACK_FULL_O <= (cnt_d == STACK_FULL_CNT);
            WAKE_O       <= wake_d;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    chk_gie_blocks_ack: assert property ((PHASE2_I && !gie_q) |=> !VEC_CALL_O)
        else $error("vector call taken with global enable clear");
    chk_call_clears_gie: assert property (VEC_CALL_O |-> !gie_q)
        else $error("global enable still set after vector call");
    chk_pin_vector: assert property (
        (ack && flag_q[SRC_PIN] && en_q[SRC_PIN]) |=> (VEC_ADDR_O == VEC_PIN)
        && (flag_q[SRC_PIN] == $past(set_ev[SRC_PIN])))
        else $error("pin request did not vector to its address");
    chk_tick_priority: assert property (
        (VEC_CALL_O && VEC_ADDR_O == VEC_TICK) |-> !$past(pend[SRC_PIN]))
        else $error("tick serviced ahead of pending pin request");
    chk_conv_vector: assert property (
        (ack && pend == 3'h4) |=> (VEC_ADDR_O == VEC_CONV))
        else $error("conversion request did not vector to its address");
    chk_full_holds_ack: assert property ((PHASE2_I && full) |=> !VEC_CALL_O
        && ($past(flag_q) == ($past(flag_q) & flag_q) || $past(ctrl_wr)))
        else $error("request acknowledged or dropped on full stack");
    chk_pin_edge_flag: assert property ((pin_prev_q && !PIN_IRQ_N_I) |=> flag_q[SRC_PIN])
        else $error("pin falling edge did not set its flag");
    chk_hw_set_wins: assert property (TICK_OVF_I |=> flag_q[SRC_TICK])
        else $error("tick overflow event lost");
    chk_flag_holds: assert property (
        (flag_q[SRC_CONV] && !ctrl_wr && !ack) |=> flag_q[SRC_CONV])
        else $error("conversion flag dropped without service or write");
    chk_return_gie: assert property (
        (SUB_RET_I && !SVC_RET_I && !ctrl_wr && !ack) |=> gie_q == $past(gie_q))
        else $error("plain return changed the global enable");
    chk_push_count: assert property (VEC_CALL_O |-> cnt_q == $past(cnt_q) + STACK_ONE)
        else $error("vector call did not push one entry");
    chk_bit7_zero: assert property (
        RVALID_O |-> (RDATA_O[AXI_DATA_W-1:REG_W-1] == '0))
        else $error("unused control bit read as one");
    chk_wake_armed: assert property (WAKE_O |-> $past(|(set_ev & armed_q)))
        else $error("wake-up from a source that was already pending");

    cov_pin_call: cover property (VEC_CALL_O && VEC_ADDR_O == VEC_PIN);
    cov_nested: cover property (VEC_CALL_O ##[1:40] VEC_CALL_O);
    cov_full_block: cover property (PHASE2_I && full && gie_q && |pend);
    cov_wake: cover property (WAKE_O);
endmodule

// *** irq_ctrl_pkg.sv ***
// Shared constants for the vectored interrupt controller.
// Assumes a single 200 MHz clock domain and an AXI4-Lite register port.
package irq_ctrl_pkg;

    // Register bus geometry.
    localparam int unsigned AXI_ADDR_W = 8;
    localparam int unsigned AXI_DATA_W = 32;
    localparam int unsigned REG_IDX_W  = 6;
    localparam int unsigned REG_W      = 8;

    // Register indices; the byte address is four times the index.
    localparam logic [REG_IDX_W-1:0] INT_CTRL_IDX = 6'h0B;
    localparam logic [REG_IDX_W-1:0] STACK_STAT_IDX = 6'h0C;

    // Field positions in interrupt_control.
    localparam int unsigned GIE_BIT      = 0;
    localparam int unsigned EN_LSB       = 1;
    localparam int unsigned FLAG_LSB     = 4;
    localparam int unsigned NUM_SRC      = 3;
    localparam logic [REG_W-1:0] INT_CTRL_RESET = 8'h00;

    // Source order is also priority order: pin, tick overflow, conversion done.
    localparam int unsigned SRC_PIN  = 0;
    localparam int unsigned SRC_TICK = 1;
    localparam int unsigned SRC_CONV = 2;

    // Program counter and vector addresses.
    localparam int unsigned PC_W = 12;
    localparam logic [PC_W-1:0] VEC_PIN  = 12'h004;
    localparam logic [PC_W-1:0] VEC_TICK = 12'h008;
    localparam logic [PC_W-1:0] VEC_CONV = 12'h00C;
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;

    // Return stack geometry.
    localparam int unsigned STACK_DEPTH = 6;
    localparam int unsigned STACK_PTR_W = 3;
    localparam logic [STACK_PTR_W-1:0] STACK_FULL_CNT = 3'h6;
    localparam logic [STACK_PTR_W-1:0] STACK_LAST     = 3'h5;
    localparam logic [STACK_PTR_W-1:0] STACK_ZERO     = 3'h0;
    localparam logic [STACK_PTR_W-1:0] STACK_ONE      = 3'h1;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** reg_access_if.sv ***
// Register access strobes between the AXI4-Lite slave and the controller core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface reg_access_if;
    import irq_ctrl_pkg::*;
    logic                 wr_stb;
    logic [REG_IDX_W-1:0] wr_idx;
    logic [REG_W-1:0]     wr_data;
    logic                 wr_lane0;
    logic                 wr_ok;
    logic                 rd_stb;
    logic [REG_IDX_W-1:0] rd_idx;
    logic [REG_W-1:0]     rd_data;
    logic                 rd_ok;

    modport bus  (output wr_stb, wr_idx, wr_data, wr_lane0, rd_stb, rd_idx,
                  input wr_ok, rd_data, rd_ok);
    modport regs (input wr_stb, wr_idx, wr_data, wr_lane0, rd_stb, rd_idx,
                  output wr_ok, rd_data, rd_ok);
endinterface

// *** axil_reg_slave.sv ***
// AXI4-Lite slave that turns bus transfers into one-cycle register strobes.
// Assumes the register side answers wr_ok, rd_ok and rd_data combinationally.
`timescale 1ns/1ps
module axil_reg_slave
    import irq_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_ni,
    // AXI4-Lite
    input  wire logic [AXI_ADDR_W-1:0] awaddr_i,
    input  wire logic                  awvalid_i,
    output logic                       awready_o,
    input  wire logic [AXI_DATA_W-1:0] wdata_i,
    input  wire logic [3:0]            wstrb_i,
    input  wire logic                  wvalid_i,
    output logic                       wready_o,
    output logic [1:0]                 bresp_o,
    output logic                       bvalid_o,
    input  wire logic                  bready_i,
    input  wire logic [AXI_ADDR_W-1:0] araddr_i,
    input  wire logic                  arvalid_i,
    output logic                       arready_o,
    output logic [AXI_DATA_W-1:0]      rdata_o,
    output logic [1:0]                 rresp_o,
    output logic                       rvalid_o,
    input  wire logic                  rready_i,
    // Register side
    reg_access_if.bus                  regs
);
    logic                  aw_held_q, aw_held_d, w_held_q, w_held_d, ar_held_q, ar_held_d;
    logic [REG_IDX_W-1:0]  awidx_q, awidx_d, aridx_q, aridx_d;
    logic [REG_W-1:0]      wdata_q, wdata_d;
    logic                  lane0_q, lane0_d;
    logic                  awready_d, wready_d, arready_d, bvalid_d, rvalid_d;
    logic [1:0]            bresp_d, rresp_d;
    logic [AXI_DATA_W-1:0] rdata_d;
    logic                  do_wr;

    assign do_wr         = aw_held_q & w_held_q & ~bvalid_o;
    assign regs.wr_stb   = do_wr;
    assign regs.wr_idx   = awidx_q;
    assign regs.wr_data  = wdata_q;
    assign regs.wr_lane0 = lane0_q;
    assign regs.rd_stb   = ar_held_q;
    assign regs.rd_idx   = aridx_q;

    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        ar_held_d = ar_held_q;
        awidx_d   = awidx_q;
        aridx_d   = aridx_q;
        wdata_d   = wdata_q;
        lane0_d   = lane0_q;
        bvalid_d  = bvalid_o;
        bresp_d   = bresp_o;
        rvalid_d  = rvalid_o;
        rresp_d   = rresp_o;
        rdata_d   = rdata_o;
        if (awvalid_i && awready_o) begin
            aw_held_d = 1'b1;
            awidx_d   = awaddr_i[AXI_ADDR_W-1:2];
        end
        if (wvalid_i && wready_o) begin
            w_held_d = 1'b1;
            wdata_d  = wdata_i[REG_W-1:0];
            lane0_d  = wstrb_i[0];
        end
        if (bvalid_o && bready_i) begin
            bvalid_d = 1'b0;
        end
        if (do_wr) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = regs.wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid_o && rready_i) begin
            rvalid_d = 1'b0;
        end
        if (arvalid_i && arready_o) begin
            ar_held_d = 1'b1;
            aridx_d   = araddr_i[AXI_ADDR_W-1:2];
        end
        if (ar_held_q) begin
            ar_held_d = 1'b0;
            rvalid_d  = 1'b1;
            rresp_d   = regs.rd_ok ? RESP_OKAY : RESP_SLVERR;
            rdata_d   = {{(AXI_DATA_W-REG_W){1'b0}}, regs.rd_data};
        end
        // Each channel is refused until the previous response has been taken.
        awready_d = ~aw_held_d & ~bvalid_d;
        wready_d  = ~w_held_d & ~bvalid_d;
        arready_d = ~ar_held_d & ~rvalid_d;
    end

    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            ar_held_q <= 1'b0;
            awidx_q   <= '0;
            aridx_q   <= '0;
            wdata_q   <= '0;
            lane0_q   <= 1'b0;
            awready_o <= 1'b0;
            wready_o  <= 1'b0;
            arready_o <= 1'b0;
            bvalid_o  <= 1'b0;
            bresp_o   <= RESP_OKAY;
            rvalid_o  <= 1'b0;
            rresp_o   <= RESP_OKAY;
            rdata_o   <= '0;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            ar_held_q <= ar_held_d;
            awidx_q   <= awidx_d;
            aridx_q   <= aridx_d;
            wdata_q   <= wdata_d;
            lane0_q   <= lane0_d;
            awready_o <= awready_d;
            wready_o  <= wready_d;
            arready_o <= arready_d;
            bvalid_o  <= bvalid_d;
            bresp_o   <= bresp_d;
            rvalid_o  <= rvalid_d;
            rresp_o   <= rresp_d;
            rdata_o   <= rdata_d;
        end
    end
endmodule

// *** return_stack_mem.sv ***
// Six-entry return address memory with a registered read port.
// Assumes the caller never reads and writes the same entry in one cycle.
`timescale 1ns/1ps
module return_stack_mem
    import irq_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_ni,
    // Write port
    input  wire logic                   wr_en_i,
    input  wire logic [STACK_PTR_W-1:0] wr_idx_i,
    input  wire logic [PC_W-1:0]        wr_data_i,
    // Read port
    input  wire logic                   rd_en_i,
    input  wire logic [STACK_PTR_W-1:0] rd_idx_i,
    output logic [PC_W-1:0]             rd_data_o
);
    logic [PC_W-1:0] entry_q [STACK_DEPTH];
    logic [PC_W-1:0] rd_data_d;

    for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_entry
        always_ff @(posedge clk_i) begin
            if (wr_en_i && (wr_idx_i == STACK_PTR_W'(i))) begin
                entry_q[i] <= wr_data_i;
            end
        end
    end

    always_comb begin
        rd_data_d = rd_data_o;
        if (rd_en_i) begin
            rd_data_d = entry_q[rd_idx_i];
        end
    end

    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            rd_data_o <= PC_RESET;
        end else begin
            rd_data_o <= rd_data_d;
        end
    end
endmodule

// *** seq_model.sv ***
// Sequencer stand-in: a second phase pulse and a moving program counter.
// Assumes the bench clock; it makes no calls or returns of its own.
`timescale 1ns/1ps
module seq_model
    import irq_ctrl_pkg::*;
(
    // Sequencer side
    input  wire logic                     clk_i,
    output logic                          phase2_o,
    output logic [irq_ctrl_pkg::PC_W-1:0] pc_o
);
    logic [1:0]      ph_q = 2'h0;
    logic [PC_W-1:0] pc_q = 12'h100;
    always_ff @(posedge clk_i) begin
        ph_q <= ph_q + 2'h1;
        pc_q <= pc_q + 12'h001;
    end
    // One pulse in four cycles, so requests wait for a machine cycle boundary.
    assign phase2_o = (ph_q == 2'h2);
    assign pc_o = pc_q;
endmodule

// *** irq_vector_ctrl_bench.sv ***
// Self-checking bench for the vectored interrupt controller.
// Assumes seq_model supplies the phase pulse and the program counter.
`timescale 1ns/1ps
module irq_vector_ctrl_bench;
    import irq_ctrl_pkg::*;
    logic CLK_I = 1'b0, RSTN_I = 1'b0, AWVALID_I = 1'b0, WVALID_I = 1'b0, BREADY_I = 1'b0;
    logic ARVALID_I = 1'b0, RREADY_I = 1'b0, PIN_IRQ_N_I = 1'b1, TICK_OVF_I = 1'b0;
    logic SUB_RET_I = 1'b0, POWER_DOWN_I = 1'b0;
    logic CONV_DONE_I = 1'b0, SVC_RET_I = 1'b0, PHASE2_I, AWREADY_O, WREADY_O, BVALID_O;
    logic ARREADY_O, RVALID_O, VEC_CALL_O, RET_VALID_O, STACK_FULL_O, WAKE_O;
    logic [7:0]  AWADDR_I = 8'h00, ARADDR_I = 8'h00, e;
    logic [3:0]  WSTRB_I = 4'h0;
    logic [31:0] WDATA_I = 32'h0, RDATA_O;
    logic [1:0]  BRESP_O, RRESP_O, r;
    logic [11:0] PC_I, VEC_ADDR_O, RET_PC_O, pc_prev, pushed;
    int          fails = 0, n_tests = 0, calls = 0, wakes = 0;
    localparam logic [7:0] CTL = {INT_CTRL_IDX, 2'b00};
    localparam logic [7:0] STS = {STACK_STAT_IDX, 2'b00};
    // One row per source: its enable bit beside the vector it should give.
    localparam logic [19:0] ROWS [3] = '{{8'h02, VEC_PIN}, {8'h04, VEC_TICK}, {8'h08, VEC_CONV}};
    irq_vector_ctrl i_irq_vector_ctrl (.CLK_I, .RSTN_I, .AWADDR_I, .AWVALID_I, .AWREADY_O,
        .WDATA_I, .WSTRB_I, .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARADDR_I,
        .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I, .PIN_IRQ_N_I,
        .TICK_OVF_I, .CONV_DONE_I, .PHASE2_I, .PC_I, .SUB_CALL_I(1'b0), .SUB_RET_I,
        .SVC_RET_I, .POWER_DOWN_I, .VEC_CALL_O, .VEC_ADDR_O, .RET_PC_O, .RET_VALID_O,
        .STACK_FULL_O, .WAKE_O);
    seq_model i_seq_model (.clk_i(CLK_I), .phase2_o(PHASE2_I), .pc_o(PC_I));
    initial forever #2.5 CLK_I = ~CLK_I;
    // Counting calls here means a pulse landing inside a bus cycle is not missed.
    // A call pushes the counter value that stood one edge before it shows.
    always @(posedge CLK_I) begin
        if (VEC_CALL_O === 1'b1) begin
            calls++;
            pushed = pc_prev;
        end
        if (WAKE_O === 1'b1) wakes++;
        pc_prev = PC_I;
    end
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic hang(input int i);
        @(posedge CLK_I);
        if (i >= 40) begin
            fails++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        int i;
        AWADDR_I <= a;
        WDATA_I <= {24'h0, d};
        WSTRB_I <= s;
        AWVALID_I <= 1'b1;
        WVALID_I <= 1'b1;
        BREADY_I <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge CLK_I);
            if (AWREADY_O === 1'b1) AWVALID_I <= 1'b0;
            if (WREADY_O === 1'b1) WVALID_I <= 1'b0;
            if (BVALID_O === 1'b1) break;
        end
        BREADY_I <= 1'b0;
        r = BRESP_O;
        hang(i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        int i;
        ARADDR_I <= a;
        ARVALID_I <= 1'b1;
        RREADY_I <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge CLK_I);
            if (ARREADY_O === 1'b1) ARVALID_I <= 1'b0;
            if (RVALID_O === 1'b1) break;
        end
        RREADY_I <= 1'b0;
        r = RRESP_O;
        check(RDATA_O, exp);
        hang(i);
    endtask
    task automatic wait_call(input logic [11:0] v);
        int i;
        for (i = 0; i < 40 && calls == 0; i++) @(posedge CLK_I);
        calls = 0;
        hang(i);
        check({20'h0, VEC_ADDR_O}, {20'h0, v});
    endtask
    task automatic pulse(input int s);
        @(posedge CLK_I);
        if (s == 0) PIN_IRQ_N_I <= 1'b0;
        if (s == 1) TICK_OVF_I <= 1'b1;
        if (s == 2) CONV_DONE_I <= 1'b1;
        if (s == 3) SVC_RET_I <= 1'b1;
        if (s == 4) SUB_RET_I <= 1'b1;
        @(posedge CLK_I);
        SUB_RET_I <= 1'b0;
        PIN_IRQ_N_I <= 1'b1;
        TICK_OVF_I <= 1'b0;
        CONV_DONE_I <= 1'b0;
        SVC_RET_I <= 1'b0;
    endtask
    initial begin
        repeat (10) @(posedge CLK_I);
        RSTN_I <= 1'b1;
        @(posedge CLK_I);
        rd(CTL, 32'h0);
        rd(STS, 32'h0);
        $display("reset test done");
        for (int s = 0; s < 3; s++) begin
            e = ROWS[s][19:12];
            wr(CTL, e | 8'h01, 4'hF);
            pulse(s);
            wait_call(ROWS[s][11:0]);
            rd(CTL, {24'h0, e});
            pulse(3);
            rd(CTL, {24'h0, e | 8'h01});
        end
        $display("vector test done");
        wr(CTL, 8'h0E, 4'hF);
        pulse(1);
        pulse(2);
        repeat (12) @(posedge CLK_I);
        check(32'(calls), 32'h0);
        rd(CTL, 32'h6E);
        wr(CTL, 8'hFF, 4'h0);
        rd(CTL, 32'h6E);
        wr(CTL, 8'hFF, 4'hF);
        wait_call(VEC_PIN);
        rd(CTL, 32'h6E);
        wr(CTL, 8'h6F, 4'hF);
        wait_call(VEC_TICK);
        wr(CTL, 8'h4F, 4'hF);
        wait_call(VEC_CONV);
        $display("priority test done");
        repeat (3) begin
            wr(CTL, 8'h13, 4'hF);
            wait_call(VEC_PIN);
        end
        check({31'h0, STACK_FULL_O}, 32'h1);
        wr(CTL, 8'h13, 4'hF);
        repeat (12) @(posedge CLK_I);
        check(32'(calls), 32'h0);
        rd(CTL, 32'h13);
        pulse(3);
        wait_call(VEC_PIN);
        $display("full stack test done");
        pulse(4);
        @(posedge CLK_I);
        check({20'h0, RET_PC_O}, {20'h0, pushed});
        check({31'h0, RET_VALID_O}, 32'h1);
        rd(CTL, 32'h02);
        $display("return test done");
        wr(CTL, 8'h20, 4'hF);
        POWER_DOWN_I <= 1'b1;
        pulse(1);
        pulse(2);
        repeat (2) @(posedge CLK_I);
        check(32'(wakes), 32'h1);
        POWER_DOWN_I <= 1'b0;
        $display("wake test done");
        wr(8'h00, 8'hFF, 4'hF);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        rd(8'h00, 32'h0);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        $display("unmapped test done");
        end_of_test();
    end
endmodule
